/* File: flash_ram_prot_checker_assertions.sv */
// port assertions for the flash and ram protection controller
// assumes i_clk_en held high, one clock domain, i_reset_n as disable
`timescale 1ns/100ps
`default_nettype none
`include "flash_ram_prot_regs.vh"
module flash_ram_prot_checker (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // flash check and loader
    input wire logic i_flash_req,
    input wire logic [1:0] i_flash_op,
    input wire logic o_flash_grant,
    input wire logic o_flash_deny,
    input wire logic o_main_mass_erase,
    input wire logic o_cpu_run,
    input wire logic o_opt_byte_error,
    input wire logic o_opt_rd_req,
    input wire logic [31:0] o_opt_rd_addr,
    // ram and dma writes
    input wire logic i_ram_wr,
    input wire logic i_ram_priv,
    input wire logic o_ram_wr_ok,
    input wire logic o_ram_bus_error,
    input wire logic i_dma_wr,
    input wire logic o_dma_wr_ok,
    input wire logic o_mgmt_irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_erase_req;
        i_flash_req && i_flash_op == `FOP_PAGE_ERASE;
    endsequence
    sequence s_early_req;
        i_flash_req && !o_cpu_run;
    endsequence
    chk_flash_one_answer: assert property (i_flash_req |=> o_flash_grant != o_flash_deny)
        else $error("flash answer not one-hot");
    chk_deny_before_run: assert property (s_early_req |=> o_flash_deny)
        else $error("flash granted before load");
    chk_mass_erase_grant: assert property (s_erase_req ##1 o_main_mass_erase |-> o_flash_grant)
        else $error("mass erase not granted");
    chk_mass_erase_cause: assert property (o_main_mass_erase |-> $past(i_flash_op) == `FOP_PAGE_ERASE)
        else $error("mass erase without page erase");
    chk_ram_one_answer: assert property (i_ram_wr |=> o_ram_wr_ok != o_ram_bus_error)
        else $error("ram write answer not one-hot");
    chk_ram_priv_ok: assert property (i_ram_wr && i_ram_priv |=> o_ram_wr_ok)
        else $error("privileged ram write refused");
    chk_dma_irq_cause: assert property (o_mgmt_irq |-> $past(i_dma_wr) && !o_dma_wr_ok)
        else $error("irq without refused dma write");
    chk_opt_addr_range: assert property (o_opt_rd_req |-> o_opt_rd_addr[31:4] == 28'h0804080 && !o_opt_rd_addr[0])
        else $error("option read address out of range");
    chk_opt_req_pulse: assert property (o_opt_rd_req |=> !o_opt_rd_req)
        else $error("option request not a pulse");
    chk_opt_err_hold: assert property (o_opt_byte_error |-> !o_cpu_run ##1 o_opt_byte_error)
        else $error("option error not held");
endmodule
bind flash_ram_protection_ctrl flash_ram_prot_checker u_checker (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_flash_req(i_flash_req), .i_flash_op(i_flash_op),
    .o_flash_grant(o_flash_grant), .o_flash_deny(o_flash_deny), .o_main_mass_erase(o_main_mass_erase),
    .o_cpu_run(o_cpu_run), .o_opt_byte_error(o_opt_byte_error), .o_opt_rd_req(o_opt_rd_req),
    .o_opt_rd_addr(o_opt_rd_addr), .i_ram_wr(i_ram_wr), .i_ram_priv(i_ram_priv), .o_ram_wr_ok(o_ram_wr_ok),
    .o_ram_bus_error(o_ram_bus_error), .i_dma_wr(i_dma_wr), .o_dma_wr_ok(o_dma_wr_ok), .o_mgmt_irq(o_mgmt_irq)
);
`default_nettype wire

/* File: flash_ram_prot_regs.vh */
// constants of the flash and ram protection block
// assumes a 32-bit system address map and 32-bit register port
`ifndef FLASH_RAM_PROT_REGS_VH
`define FLASH_RAM_PROT_REGS_VH

// flash address map
`define MAIN_FLASH_BASE 32'h08000000
`define MAIN_FLASH_LAST 32'h0801FFFF
`define FACTORY_BASE 32'h08040000
`define FACTORY_LAST 32'h080407FF
`define USER_INFO_BASE 32'h08040800
`define USER_INFO_LAST 32'h08040FFF
`define BOOT_WP_LAST 32'h08001FFF

// write-protection regions: 16 regions of 4 pages, 8 kB each
`define WP_REGIONS 16
`define WP_REGION_LSB 13
`define WP_REGION_MSB 16

// option bytes
`define OPT_COUNT 4'h8
`define OPT_LAST_IDX 3'h7
`define OPT_IDX_RDP 3'h0
`define OPT_IDX_WP_LO 3'h4
`define OPT_IDX_WP_HI 3'h5
`define RDP_OFF_KEY 8'hA5
`define OPT_ERASED 8'hFF

// flash operations
`define FOP_READ 2'h0
`define FOP_PROGRAM 2'h1
`define FOP_PAGE_ERASE 2'h2
`define FOP_FETCH 2'h3

// ram map: 12 kB in 32-byte blocks
`define RAM_BASE 32'h20000000
`define RAM_BYTES 32'h00003000
`define RAM_BLOCK_LSB 5
`define RAM_BLOCKS 384
`define RAM_MAP_WORDS 12

// register byte offsets
`define REG_MAP_FIRST 8'h00
`define REG_MAP_LAST 8'h2C
`define REG_DMA_CTRL 8'h40
`define REG_DMA_FAULT_ADDR 8'h44
`define REG_DMA_FAULT_ID 8'h48
`define REG_STATUS 8'h4C
`define REG_OPT_WP 8'h50

// field positions
`define DMA_CTRL_EN_BIT 0
`define ST_RDP_BIT 0
`define ST_INTRUSION_BIT 1
`define ST_OPT_ERR_BIT 2
`define ST_LOADED_BIT 3
`define ST_DMA_FAULT_BIT 4

`endif

/* File: flash_ram_protection_ctrl.v */
// flash and ram protection controller top
// assumes a flash option port answering reads, single clock domain, an always-on por reset
//
// Contract
// - each bit guards four main flash pages
// - protect bits active low, erased means open
// - write protection changes only after reset
// - protected region rejects program and erase
// - read protection off only for 0xA5
// - read protection state changes only at reset
// - debugger connection latches intrusion flag
// - intrusion clears by pin reset, debugger gone
// - protection plus intrusion disconnects all flash (here only reads and fetches are cut off)
// - erasing byte zero while protected mass-erases
// - protected mode locks bottom four pages
// - byte four then five map 8 kB regions
// - read protection covers all three blocks
// - one bitmap bit per 32-byte block
// - user write to protected block errors
// - privileged writes and all reads allowed
// - enabled dma write hit raises interrupt
// - dma fault captures address and source
// - upper byte holds inverse of data byte
// - mismatched inverse raises error, halts cpu
// - byte zero read from user info start
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "flash_ram_prot_regs.vh"

module flash_ram_protection_ctrl #(
    parameter DMA_ID_W = 3
) (
    // clock, enable and resets
    input wire i_core_clk,
    input wire i_reset_n,
    input wire i_por_n,
    input wire i_clk_en,
    input wire i_reset_from_pin,
    // debugger presence
    input wire i_debugger_connected,
    // option byte loader port
    output reg o_opt_rd_req,
    output reg [31:0] o_opt_rd_addr,
    input wire i_opt_rd_valid,
    input wire [15:0] i_opt_rd_data,
    output reg o_opt_byte_error,
    output reg o_cpu_run,
    // flash access check
    input wire i_flash_req,
    input wire [1:0] i_flash_op,
    input wire [31:0] i_flash_addr,
    output reg o_flash_grant,
    output reg o_flash_deny,
    output reg o_main_mass_erase,
    // cpu/debugger ram writes
    input wire i_ram_wr,
    input wire [31:0] i_ram_addr,
    input wire i_ram_priv,
    output reg o_ram_wr_ok,
    output reg o_ram_bus_error,
    // peripheral dma ram writes
    input wire i_dma_wr,
    input wire [31:0] i_dma_addr,
    input wire [DMA_ID_W-1:0] i_dma_id,
    output reg o_dma_wr_ok,
    output reg o_mgmt_irq,
    // register port
    input wire [7:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [31:0] o_reg_rdata
);

    // loader states
    localparam ST_REQ = 4'b0001;
    localparam ST_WAIT = 4'b0010;
    localparam ST_DONE = 4'b0100;
    localparam ST_ERR = 4'b1000;

    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [2:0] opt_idx_q;
    reg [7:0] rdp_byte_q;
    reg [15:0] wp_n_q;
    reg rdp_active_q;
    reg intrusion_q;
    reg first_cycle_q;
    reg dma_en_q;
    reg [31:0] fault_addr_q;
    reg [DMA_ID_W-1:0] fault_id_q;
    reg fault_seen_q;

    wire opt_ok;
    wire flash_off;
    wire wp_hit;
    wire cpu_hit;
    wire dma_hit;
    wire flash_block;
    wire is_read;
    wire is_write_op;
    wire user_opt_erase;
    wire dma_fault;
    wire map_wr;
    wire [3:0] map_idx;
    wire [7:0] map_off;
    wire [31:0] map_rdata;

    // flash block decode, used for read and fetch requests only
    function in_flash;
        input [31:0] a;
        begin
            in_flash = ((a >= `MAIN_FLASH_BASE) && (a <= `MAIN_FLASH_LAST)) ||
                       ((a >= `FACTORY_BASE) && (a <= `FACTORY_LAST)) ||
                       ((a >= `USER_INFO_BASE) && (a <= `USER_INFO_LAST));
        end
    endfunction

    // register offset decode
    function is_reg;
        input [7:0] a;
        input [7:0] off;
        begin
            is_reg = (a == off);
        end
    endfunction

    // ---------------- option byte loader ----------------
    assign opt_ok = (i_opt_rd_data[15:8] == ~i_opt_rd_data[7:0]);

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_REQ: begin
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (i_opt_rd_valid) begin
                    if (!opt_ok) begin
                        state_d = ST_ERR;
                    end else if (opt_idx_q == `OPT_LAST_IDX) begin
                        state_d = ST_DONE;
                    end else begin
                        state_d = ST_REQ;
                    end
                end
            end
            ST_DONE: begin
                state_d = ST_DONE;
            end
            ST_ERR: begin
                state_d = ST_ERR;
            end
            default: begin
                state_d = ST_ERR;
            end
        endcase
    end

    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= ST_REQ;
            opt_idx_q <= `OPT_IDX_RDP;
            rdp_byte_q <= `OPT_ERASED;
            wp_n_q <= {`OPT_ERASED, `OPT_ERASED};
            rdp_active_q <= 1'b1;
            o_opt_rd_req <= 1'b0;
            o_opt_rd_addr <= `USER_INFO_BASE;
            o_opt_byte_error <= 1'b0;
            o_cpu_run <= 1'b0;
        end else if (i_clk_en) begin
            state_q <= state_d;
            o_opt_rd_req <= (state_q == ST_REQ);
            // byte zero sits at the first half-word of the user info block
            o_opt_rd_addr <= `USER_INFO_BASE + {28'h0000000, opt_idx_q, 1'b0};
            if ((state_q == ST_WAIT) && i_opt_rd_valid && opt_ok) begin
                // protection values only load here, once per reset
                if (opt_idx_q == `OPT_IDX_RDP) begin
                    rdp_byte_q <= i_opt_rd_data[7:0];
                end
                if (opt_idx_q == `OPT_IDX_WP_LO) begin
                    wp_n_q[7:0] <= i_opt_rd_data[7:0];
                end
                if (opt_idx_q == `OPT_IDX_WP_HI) begin
                    wp_n_q[15:8] <= i_opt_rd_data[7:0];
                end
                if (opt_idx_q != `OPT_LAST_IDX) begin
                    opt_idx_q <= opt_idx_q + 3'h1;
                end
            end
            if (state_d == ST_DONE) begin
                rdp_active_q <= (rdp_byte_q != `RDP_OFF_KEY);
                o_cpu_run <= 1'b1;
            end
            if (state_d == ST_ERR) begin
                // protection stays forced on, cpu held
                rdp_active_q <= 1'b1;
                o_opt_byte_error <= 1'b1;
                o_cpu_run <= 1'b0;
            end
        end
    end

    // ---------------- intrusion latch (always-on) ----------------
    always @(posedge i_core_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            intrusion_q <= 1'b0;
            first_cycle_q <= 1'b0;
        end else if (i_clk_en) begin
            // first edge after reset
            first_cycle_q <= !i_reset_n;
            if (i_debugger_connected) begin
                intrusion_q <= 1'b1;
            end else if (first_cycle_q && i_reset_n && i_reset_from_pin) begin
                intrusion_q <= 1'b0;
            end
        end
    end

    // ---------------- flash access check ----------------
    flash_wp_check #(
        .REGIONS(`WP_REGIONS)
    ) u_wp (
        .i_addr(i_flash_addr),
        .i_wp_n(wp_n_q),
        .i_rdp_active(rdp_active_q),
        .o_protected(wp_hit)
    );

    assign flash_off = rdp_active_q && intrusion_q;
    assign is_read = (i_flash_op == `FOP_READ) || (i_flash_op == `FOP_FETCH);
    assign is_write_op = (i_flash_op == `FOP_PROGRAM) || (i_flash_op == `FOP_PAGE_ERASE);
    // with read protection on and intrusion set, reads and fetches of any flash block are cut off
    assign flash_block = (is_read && flash_off && in_flash(i_flash_addr)) ||
                         (is_write_op && wp_hit);
    assign user_opt_erase = (i_flash_op == `FOP_PAGE_ERASE) &&
                            (i_flash_addr >= `USER_INFO_BASE) && (i_flash_addr <= `USER_INFO_LAST);

    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_flash_grant <= 1'b0;
            o_flash_deny <= 1'b0;
            o_main_mass_erase <= 1'b0;
        end else if (i_clk_en) begin
            o_flash_grant <= i_flash_req && o_cpu_run && !flash_block;
            o_flash_deny <= i_flash_req && (!o_cpu_run || flash_block);
            o_main_mass_erase <= i_flash_req && o_cpu_run && user_opt_erase && rdp_active_q;
        end
    end

    // ---------------- ram protection ----------------
    assign map_off = i_reg_addr - `REG_MAP_FIRST;
    assign map_idx = map_off[5:2];
    // aligned words only
    assign map_wr = i_reg_wr && (i_reg_addr <= `REG_MAP_LAST) && (i_reg_addr[1:0] == 2'b00);

    ram_prot_bitmap #(
        .WORDS(`RAM_MAP_WORDS)
    ) u_map (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_map_wr(map_wr),
        .i_map_idx(map_idx),
        .i_map_wdata(i_reg_wdata),
        .o_map_rdata(map_rdata),
        .i_cpu_addr(i_ram_addr),
        .i_dma_addr(i_dma_addr),
        .o_cpu_hit(cpu_hit),
        .o_dma_hit(dma_hit)
    );

    // trap only when enabled
    assign dma_fault = i_dma_wr && dma_en_q && dma_hit;

    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ram_wr_ok <= 1'b0;
            o_ram_bus_error <= 1'b0;
            o_dma_wr_ok <= 1'b0;
            o_mgmt_irq <= 1'b0;
            dma_en_q <= 1'b0;
            fault_addr_q <= 32'h00000000;
            fault_id_q <= {DMA_ID_W{1'b0}};
            fault_seen_q <= 1'b0;
        end else if (i_clk_en) begin
            // user writes to a protected block fail, privileged always pass
            o_ram_wr_ok <= i_ram_wr && (i_ram_priv || !cpu_hit);
            o_ram_bus_error <= i_ram_wr && !i_ram_priv && cpu_hit;
            o_dma_wr_ok <= i_dma_wr && !dma_fault;
            o_mgmt_irq <= dma_fault;
            if (i_reg_wr && is_reg(i_reg_addr, `REG_DMA_CTRL)) begin
                dma_en_q <= i_reg_wdata[`DMA_CTRL_EN_BIT];
            end
            if (dma_fault) begin
                fault_addr_q <= i_dma_addr;
                fault_id_q <= i_dma_id;
            end
            // a new fault wins over a clear in the same cycle
            if (dma_fault) begin
                fault_seen_q <= 1'b1;
            end else if (i_reg_wr && is_reg(i_reg_addr, `REG_STATUS) && i_reg_wdata[`ST_DMA_FAULT_BIT]) begin
                fault_seen_q <= 1'b0;
            end
        end
    end

    // ---------------- register read ----------------
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= 32'h00000000;
        end else if (i_clk_en) begin
            // zero unless read
            o_reg_rdata <= 32'h00000000;
            if (i_reg_rd) begin
                if ((i_reg_addr <= `REG_MAP_LAST) && (i_reg_addr[1:0] == 2'b00)) begin
                    o_reg_rdata <= map_rdata;
                end else if (is_reg(i_reg_addr, `REG_DMA_CTRL)) begin
                    o_reg_rdata[`DMA_CTRL_EN_BIT] <= dma_en_q;
                end else if (is_reg(i_reg_addr, `REG_DMA_FAULT_ADDR)) begin
                    o_reg_rdata <= fault_addr_q;
                end else if (is_reg(i_reg_addr, `REG_DMA_FAULT_ID)) begin
                    o_reg_rdata[DMA_ID_W-1:0] <= fault_id_q;
                end else if (is_reg(i_reg_addr, `REG_STATUS)) begin
                    o_reg_rdata[`ST_RDP_BIT] <= rdp_active_q;
                    o_reg_rdata[`ST_INTRUSION_BIT] <= intrusion_q;
                    o_reg_rdata[`ST_OPT_ERR_BIT] <= o_opt_byte_error;
                    o_reg_rdata[`ST_LOADED_BIT] <= o_cpu_run;
                    o_reg_rdata[`ST_DMA_FAULT_BIT] <= fault_seen_q;
                end else if (is_reg(i_reg_addr, `REG_OPT_WP)) begin
                    o_reg_rdata[15:0] <= wp_n_q;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: flash_ram_protection_ctrl_bench.sv */
// self-checking bench for the flash and ram protection controller
// assumes the option model answers the loader and i_clk_en stays high
`timescale 1ns/100ps
`default_nettype none
`include "flash_ram_prot_regs.vh"
module flash_ram_protection_ctrl_bench;
    logic clk = 0, rst_n = 0, por_n = 0, from_pin = 1, dbg = 0, slow = 0, m_bad = 0;
    logic req = 0, rwr = 0, priv = 0, dwr = 0, reg_wr = 0, reg_rd = 0;
    logic [1:0] fop = 0;
    logic [31:0] faddr = 0, raddr = 0, daddr = 0, wdata = 0;
    logic [2:0] did = 0;
    logic [7:0] radr = 0;
    int num_errors = 0, tests_run = 0;
    wire o_opt_rd_req, opt_valid, o_opt_byte_error, o_cpu_run, o_flash_grant, o_flash_deny;
    wire o_main_mass_erase, o_ram_wr_ok, o_ram_bus_error, o_dma_wr_ok, o_mgmt_irq;
    wire [31:0] o_opt_rd_addr, o_reg_rdata;
    wire [15:0] opt_data;
    always #2.5 clk = ~clk;
    flash_ram_protection_ctrl #(.DMA_ID_W(3)) u_dut (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_por_n(por_n), .i_clk_en(1'b1), .i_reset_from_pin(from_pin),
        .i_debugger_connected(dbg), .o_opt_rd_req(o_opt_rd_req), .o_opt_rd_addr(o_opt_rd_addr),
        .i_opt_rd_valid(opt_valid), .i_opt_rd_data(opt_data), .o_opt_byte_error(o_opt_byte_error),
        .o_cpu_run(o_cpu_run), .i_flash_req(req), .i_flash_op(fop), .i_flash_addr(faddr),
        .o_flash_grant(o_flash_grant), .o_flash_deny(o_flash_deny), .o_main_mass_erase(o_main_mass_erase),
        .i_ram_wr(rwr), .i_ram_addr(raddr), .i_ram_priv(priv), .o_ram_wr_ok(o_ram_wr_ok),
        .o_ram_bus_error(o_ram_bus_error), .i_dma_wr(dwr), .i_dma_addr(daddr), .i_dma_id(did),
        .o_dma_wr_ok(o_dma_wr_ok), .o_mgmt_irq(o_mgmt_irq), .i_reg_addr(radr), .i_reg_wdata(wdata),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(o_reg_rdata)
    );
    opt_flash_model u_model (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_req(o_opt_rd_req), .i_addr(o_opt_rd_addr),
        .i_slow(slow), .i_bad(m_bad), .o_valid(opt_valid), .o_data(opt_data)
    );
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic restart(input logic [7:0] rdp, w4, w5, input logic pin, bad);
        int n;
        u_model.opt_byte[0] = rdp;
        u_model.opt_byte[4] = w4;
        u_model.opt_byte[5] = w5;
        m_bad = bad;
        @(posedge clk);
        from_pin <= pin;
        rst_n <= 0;
        repeat (12) @(posedge clk);
        rst_n <= 1;
        for (n = 0; n < 200 && o_cpu_run !== 1'b1 && o_opt_byte_error !== 1'b1; n++) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1;
        radr <= a;
        wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1;
        radr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 chk(name, e, o_reg_rdata);
    endtask
    task automatic flash(input logic [1:0] op, input logic [31:0] a, input logic g, input logic me);
        @(posedge clk);
        req <= 1;
        fop <= op;
        faddr <= a;
        @(posedge clk);
        req <= 0;
        #1 chk("flash_grant", g, o_flash_grant);
        chk("mass_erase", me, o_main_mass_erase);
    endtask
    task automatic ram(input logic [31:0] a, input logic p, input logic e);
        @(posedge clk);
        rwr <= 1;
        raddr <= a;
        priv <= p;
        @(posedge clk);
        rwr <= 0;
        #1 chk("ram_bus_error", e, o_ram_bus_error);
        chk("ram_wr_ok", !e, o_ram_wr_ok);
    endtask
    task automatic dma(input logic [31:0] a, input logic [2:0] id, input logic irq);
        @(posedge clk);
        dwr <= 1;
        daddr <= a;
        did <= id;
        @(posedge clk);
        dwr <= 0;
        #1 chk("mgmt_irq", irq, o_mgmt_irq);
        chk("dma_wr_ok", !irq, o_dma_wr_ok);
    endtask
    task automatic t_wp_map;
        restart(`RDP_OFF_KEY, 8'hFE, 8'h7F, 1, 0);
        rd("status", `REG_STATUS, 32'h8);
        flash(`FOP_PROGRAM, 32'h08000000, 0, 0);
        flash(`FOP_PAGE_ERASE, 32'h08001FFE, 0, 0);
        flash(`FOP_PROGRAM, 32'h08002000, 1, 0);
        flash(`FOP_PAGE_ERASE, 32'h0801E000, 0, 0);
        flash(`FOP_PROGRAM, 32'h0801DFFE, 1, 0);
        flash(`FOP_FETCH, 32'h08000000, 1, 0);
        flash(`FOP_PAGE_ERASE, `USER_INFO_BASE, 1, 0);
        flash(`FOP_PROGRAM, `USER_INFO_BASE, 1, 0);
        wr(`REG_OPT_WP, 32'h0);
        rd("wp_bits", `REG_OPT_WP, 32'h7FFE);
        rd("status", `REG_STATUS, 32'h8);
    endtask
    task automatic t_read_prot;
        slow = 1;
        restart(8'h00, 8'hFF, 8'h00, 1, 0);
        rd("status", `REG_STATUS, 32'h9);
        flash(`FOP_PROGRAM, 32'h08001000, 0, 0);
        flash(`FOP_PROGRAM, 32'h08002000, 1, 0);
        flash(`FOP_READ, 32'h08000000, 1, 0);
        flash(`FOP_PAGE_ERASE, `USER_INFO_BASE, 1, 1);
        @(posedge clk);
        dbg <= 1;
        repeat (3) @(posedge clk);
        dbg <= 0;
        rd("status", `REG_STATUS, 32'hB);
        flash(`FOP_READ, 32'h08000000, 0, 0);
        flash(`FOP_FETCH, 32'h0801FFFC, 0, 0);
        flash(`FOP_READ, `FACTORY_BASE, 0, 0);
        flash(`FOP_READ, `USER_INFO_BASE, 0, 0);
        @(posedge clk) dbg <= 1;
        restart(`OPT_ERASED, 8'hFF, 8'hFF, 1, 0);
        rd("status", `REG_STATUS, 32'hB);
        @(posedge clk) dbg <= 0;
        restart(`OPT_ERASED, 8'hFF, 8'hFF, 0, 0);
        rd("status", `REG_STATUS, 32'hB);
        restart(`OPT_ERASED, 8'hFF, 8'hFF, 1, 0);
        rd("status", `REG_STATUS, 32'h9);
        slow = 0;
    endtask
    task automatic t_ram_map;
        rd("map0", `REG_MAP_FIRST, 32'h0);
        rd("dma_ctrl", `REG_DMA_CTRL, 32'h0);
        wr(`REG_MAP_FIRST, 32'h2);
        wr(`REG_MAP_LAST, 32'h80000000);
        wr(8'h30, 32'hFFFFFFFF);
        rd("map11", `REG_MAP_LAST, 32'h80000000);
        rd("unmapped", 8'h30, 32'h0);
        ram(32'h20000020, 0, 1);
        ram(32'h2000003F, 0, 1);
        ram(32'h20000040, 0, 0);
        ram(32'h2000001F, 0, 0);
        ram(32'h20000020, 1, 0);
        ram(32'h20002FE0, 0, 1);
    endtask
    task automatic t_dma_trap;
        dma(32'h20000024, 3'h5, 0);
        wr(`REG_DMA_CTRL, 32'h1);
        dma(32'h20000060, 3'h2, 0);
        dma(32'h20000024, 3'h5, 1);
        rd("fault_addr", `REG_DMA_FAULT_ADDR, 32'h20000024);
        rd("fault_id", `REG_DMA_FAULT_ID, 32'h5);
        rd("status", `REG_STATUS, 32'h19);
        wr(`REG_STATUS, 32'h10);
        rd("status", `REG_STATUS, 32'h9);
    endtask
    task automatic t_opt_error;
        restart(`RDP_OFF_KEY, 8'hFF, 8'hFF, 1, 1);
        chk("opt_byte_error", 1, o_opt_byte_error);
        chk("cpu_run", 0, o_cpu_run);
        flash(`FOP_READ, 32'h08002000, 0, 0);
    endtask
    initial begin
        #20 por_n = 1;
        t_wp_map;
        t_read_prot;
        t_ram_map;
        t_dma_trap;
        t_opt_error;
        end_of_test;
    end
    initial begin
        #50000;
        num_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire

/* File: flash_wp_check.v */
// flash write-protection region check, combinational
// assumes option-byte write-protect bits already latched by the parent
`timescale 1ns/100ps
`default_nettype none
`include "flash_ram_prot_regs.vh"

module flash_wp_check #(
    parameter REGIONS = `WP_REGIONS
) (
    // address and protection state
    input wire [31:0] i_addr,
    input wire [REGIONS-1:0] i_wp_n,
    input wire i_rdp_active,
    // result
    output wire o_protected
);

    wire in_main;
    wire boot_hit;
    wire [REGIONS-1:0] region_hit;

    assign in_main = (i_addr >= `MAIN_FLASH_BASE) && (i_addr <= `MAIN_FLASH_LAST);

    genvar g;
    generate
        for (g = 0; g < REGIONS; g = g + 1) begin : g_region
            // one bit per 8 kB region, low bit means protected
            assign region_hit[g] = in_main && (i_addr[`WP_REGION_MSB:`WP_REGION_LSB] == g) && !i_wp_n[g];
        end
    endgenerate

    // bottom four pages locked while read protection is on
    assign boot_hit = i_rdp_active && (i_addr >= `MAIN_FLASH_BASE) && (i_addr <= `BOOT_WP_LAST);

    assign o_protected = boot_hit || (|region_hit);

endmodule
`default_nettype wire

/* File: opt_flash_model.sv */
// behavioural option half-word store answering the option loader
// assumes one loader request outstanding at a time
`timescale 1ns/100ps
`default_nettype none
module opt_flash_model (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // loader request and bench controls
    input wire logic i_req,
    input wire logic [31:0] i_addr,
    input wire logic i_slow,
    input wire logic i_bad,
    // answer
    output logic o_valid,
    output logic [15:0] o_data
);
    logic [7:0] opt_byte [0:7] = '{default: 8'hFF};
    logic [2:0] cnt;
    logic [2:0] idx;
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt <= 3'h0;
            idx <= 3'h0;
            o_valid <= 1'b0;
            o_data <= 16'h00FF;
        end else begin
            o_valid <= 1'b0;
            o_data <= ~o_data;
            if (cnt == 3'h1) begin
                o_valid <= 1'b1;
                o_data <= {~opt_byte[idx] ^ {7'h00, i_bad}, opt_byte[idx]};
            end
            if (cnt != 3'h0) begin
                cnt <= cnt - 3'h1;
            end
            if (i_req) begin
                cnt <= i_slow ? 3'h4 : 3'h1;
                idx <= i_addr[3:1];
            end
        end
    end
endmodule
`default_nettype wire

/* File: ram_prot_bitmap.v */
// ram write-protection bitmap, one bit per 32-byte block
// assumes word writes from the parent register port
`timescale 1ns/100ps
`default_nettype none
`include "flash_ram_prot_regs.vh"

module ram_prot_bitmap #(
    parameter WORDS = `RAM_MAP_WORDS
) (
    // clock and reset
    input wire i_core_clk,
    input wire i_reset_n,
    input wire i_clk_en,
    // bitmap register access
    input wire i_map_wr,
    input wire [3:0] i_map_idx,
    input wire [31:0] i_map_wdata,
    output wire [31:0] o_map_rdata,
    // lookups
    input wire [31:0] i_cpu_addr,
    input wire [31:0] i_dma_addr,
    output wire o_cpu_hit,
    output wire o_dma_hit
);

    reg [31:0] map_q [0:WORDS-1];
    integer i;

    // bit of the map guarding a ram address, zero outside ram
    function blk_prot;
        input [31:0] addr;
        reg [31:0] off;
        reg [31:0] blk;
        begin
            off = addr - `RAM_BASE;
            blk = off >> `RAM_BLOCK_LSB;
            if ((addr >= `RAM_BASE) && (off < `RAM_BYTES) && (blk[31:5] < WORDS)) begin
                blk_prot = map_q[blk[8:5]][blk[4:0]];
            end else begin
                blk_prot = 1'b0;
            end
        end
    endfunction

    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (i = 0; i < WORDS; i = i + 1) begin
                map_q[i] <= 32'h00000000;
            end
        end else if (i_clk_en && i_map_wr && (i_map_idx < WORDS)) begin
            map_q[i_map_idx] <= i_map_wdata;
        end
    end

    assign o_map_rdata = (i_map_idx < WORDS) ? map_q[i_map_idx] : 32'h00000000;
    assign o_cpu_hit = blk_prot(i_cpu_addr);
    assign o_dma_hit = blk_prot(i_dma_addr);

endmodule
`default_nettype wire
